/* File: rtl/dspid_pkg.sv */
package dspid_pkg;
	localparam int WORD_W = 16;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR = 3'h4;
	// high byte patterns
	localparam logic [7:0] HB_LD_MULT_STORE = 8'h71;
	localparam logic [7:0] HB_LD_MULT_SUB = 8'h74;
	localparam logic [7:0] HB_MULT_ACC = 8'ha2;
	localparam logic [7:0] HB_MULT_ACC_MOVE = 8'ha3;
	localparam logic [7:0] HB_MOD_AUX = 8'h8b;
	localparam logic [7:0] HB_MULT = 8'h54;
	localparam logic [7:0] HB_MULT_ADD = 8'h50;
	localparam logic [7:0] HB_MULT_SUB = 8'h51;
	localparam logic [7:0] HB_NORM = 8'ha0;
	localparam logic [7:0] HB_POP_MEM = 8'h8a;
	localparam logic [7:0] HB_PUSH_MEM = 8'h76;
	localparam logic [7:0] HB_REPEAT_IMM = 8'hbb;
	localparam logic [7:0] HB_REPEAT_MEM = 8'h0b;
	localparam logic [7:0] HB_SQR_SUB = 8'h53;
	localparam logic [7:0] HB_SQR_ADD = 8'h52;
	localparam logic [7:0] HB_STORE_LONG = 8'hae;
	localparam logic [7:0] HB_SUB_BORROW = 8'h64;
	localparam logic [7:0] HB_SUB_NOSX = 8'h66;
	localparam logic [7:0] HB_ZERO_LOAD_RND = 8'h68;
	localparam logic [7:0] HB_PROD_SHIFT = 8'hbf;
	localparam logic [7:0] HB_MISC = 8'hbe;
	localparam logic [4:0] LB_LOAD_ARP = 5'h11;
	localparam logic [11:0] TOP_OR_IMM = 12'hbfc;
	localparam logic [11:0] TOP_XOR_IMM = 12'hbfd;
	localparam logic [11:0] TOP_STATUS = 12'hbe4;
	localparam logic [2:0] TOP3_MULT_IMM = 3'h6;
	localparam logic [3:0] TOP4_STORE_ACC = 4'h9;
	localparam logic [5:0] TOP6_COND_RET = 6'h3b;
	localparam logic [15:0] W_OR_16 = 16'hbe82;
	localparam logic [15:0] W_XOR_16 = 16'hbe83;
	localparam logic [15:0] W_PROD_TO_ACC = 16'hbe03;
	localparam logic [15:0] W_POP_ACC = 16'hbe32;
	localparam logic [15:0] W_PUSH_ACC = 16'hbe3c;
	localparam logic [15:0] W_RETURN = 16'hef00;
	typedef enum logic [5:0] {
		DSPID_OP_NONE,
		DSPID_OP_LOAD_MULT_STORE_PRODUCT,
		DSPID_OP_LOAD_MULT_SUB_PRODUCT,
		DSPID_OP_MULTIPLY_ACCUMULATE,
		DSPID_OP_MULTIPLY_ACCUMULATE_MOVE,
		DSPID_OP_LOAD_ARP,
		DSPID_OP_MODIFY_AUX_REGISTER,
		DSPID_OP_MULTIPLY_OP,
		DSPID_OP_MULTIPLY_IMM,
		DSPID_OP_MULTIPLY_ADD_PREV,
		DSPID_OP_MULTIPLY_SUB_PREV,
		DSPID_OP_NORMALIZE,
		DSPID_OP_OR_IMM,
		DSPID_OP_OR_IMM16,
		DSPID_OP_PRODUCT_TO_ACC,
		DSPID_OP_POP_TO_MEMORY,
		DSPID_OP_POP_TO_ACC,
		DSPID_OP_PUSH_FROM_ACC,
		DSPID_OP_PUSH_FROM_MEMORY,
		DSPID_OP_COND_RETURN,
		DSPID_OP_RETURN,
		DSPID_OP_REPEAT_NEXT,
		DSPID_OP_STORE_ACC_HIGH,
		DSPID_OP_STORE_ACC_LOW,
		DSPID_OP_SET_STATUS_CONTROL,
		DSPID_OP_SQUARE_SUB_PREV,
		DSPID_OP_SQUARE_ADD_PREV,
		DSPID_OP_STORE_LONG_CONSTANT,
		DSPID_OP_SUBTRACT_BORROW,
		DSPID_OP_SUBTRACT_NO_SIGNEXT,
		DSPID_OP_XOR_IMM,
		DSPID_OP_XOR_IMM16,
		DSPID_OP_ZERO_LOAD_HIGH_ROUND,
		DSPID_OP_SET_PRODUCT_SHIFT
	} dspid_op_t;
	typedef enum logic [3:0] {
		DSPID_ST_ENABLE_INT = 4'h0,
		DSPID_ST_DISABLE_INT = 4'h1,
		DSPID_ST_CLR_OVM = 4'h2,
		DSPID_ST_SET_OVM = 4'h3,
		DSPID_ST_BLOCK_DATA = 4'h4,
		DSPID_ST_BLOCK_PROG = 4'h5,
		DSPID_ST_CLR_SXM = 4'h6,
		DSPID_ST_SET_SXM = 4'h7,
		DSPID_ST_CLR_TC = 4'ha,
		DSPID_ST_SET_TC = 4'hb,
		DSPID_ST_CLR_EXT_FLAG = 4'hc,
		DSPID_ST_SET_EXT_FLAG = 4'hd,
		DSPID_ST_CLR_C = 4'he,
		DSPID_ST_SET_C = 4'hf
	} dspid_status_t;
	typedef enum {
		DSPID_S_FIRST,
		DSPID_S_SECOND
	} dspid_state_t;
endpackage

/* File: rtl/dspid_decode.sv */
// Notes on behaviour
// - 0111 0001 plus address: load multiplicand, product to accumulator; 1 word 1 cycle.
// - 0111 0100 plus address: load multiplicand, subtract product; 1 word 1 cycle.
// - 1010 0010 and 1010 0011: multiply-accumulate forms, 2 words 3 cycles.
// - 1000 1011 1000 1xxx loads pointer; other 1000 1011 modifies aux register.
// - 0101 0100 multiply by operand; 110 plus 13-bit immediate multiplies immediate.
// - 0101 0000: multiply and add previous product, one cycle.
// - 0101 0001: multiply and subtract previous product, one cycle.
// - 1010 0000 plus address: normalize accumulator, one cycle.
// - 1011 1111 1100 shift, or be82: OR immediate, 2 words 2 cycles.
// - word be03 copies product register into accumulator, one cycle.
// - 1000 1010 pops stack to memory; be32 pops to low accumulator.
// - be3c pushes low accumulator; 0111 0110 pushes memory word.
// - 1110 11 conditional return, 4 cycles taken, 2 not; ef00 return 4.
// - 1011 1011 immediate or 0000 1011 memory count repeats next instruction.
// - 1001 select shift: store accumulator high when select 1, low when 0.
// - 1011 1110 0100 nibble chooses a status action, one cycle each; nibbles 8 and 9 decode as illegal.
// - 0101 0011 square subtract previous; 0101 0010 square accumulate.
// - 1010 1110: two words, writes second-word constant to memory.
// - 0110 0100 subtract with borrow; 0110 0110 subtract without sign extension.
// - 1011 1111 1101 shift, or be83: XOR immediate, 2 words 2 cycles.
// - 0110 1000: zero low, load high accumulator, round, one cycle.
// - 1011 1111 plus address: write product shift mode, one cycle.
module dspid_decode #(
	parameter int WORD_W = dspid_pkg::WORD_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fetch_valid,
	input wire logic [WORD_W-1:0] fetch_word,
	input wire logic cond_true,
	output logic fetch_ready_r,
	output logic [15:0] pc_r,
	output logic issue_valid_r,
	output dspid_pkg::dspid_op_t op_r,
	output logic [2:0] cycles_r,
	output logic two_word_r,
	output logic [WORD_W-1:0] long_const_r,
	output logic indirect_r,
	output logic [6:0] direct_offset_r,
	output logic [7:0] indirect_ctrl_r,
	output logic [2:0] aux_reg_index_r,
	output logic [3:0] shift_count_field_r,
	output logic [12:0] immediate_r,
	output logic [1:0] condition_type_field_r,
	output logic [7:0] condition_mask_field_r,
	output dspid_pkg::dspid_status_t status_action_r,
	output logic illegal_r
);
	dspid_pkg::dspid_state_t state_r;
	dspid_pkg::dspid_op_t op_nxt;
	logic two_nxt;
	logic [2:0] cyc_nxt;
	logic [7:0] hb;
	logic [15:0] w;
	logic legal_nxt;

	assign w = fetch_word[15:0];
	assign hb = w[15:8];

	always_comb
	begin
		op_nxt = dspid_pkg::DSPID_OP_NONE;
		two_nxt = 1'b0;
		cyc_nxt = dspid_pkg::CYC_ONE;
		legal_nxt = 1'b1;
		// full-word forms first
		if (w == dspid_pkg::W_OR_16)
		begin
			op_nxt = dspid_pkg::DSPID_OP_OR_IMM16;
			two_nxt = 1'b1;
			cyc_nxt = dspid_pkg::CYC_TWO;
		end
		else if (w == dspid_pkg::W_XOR_16)
		begin
			op_nxt = dspid_pkg::DSPID_OP_XOR_IMM16;
			two_nxt = 1'b1;
			cyc_nxt = dspid_pkg::CYC_TWO;
		end
		else if (w == dspid_pkg::W_PROD_TO_ACC)
			op_nxt = dspid_pkg::DSPID_OP_PRODUCT_TO_ACC;
		else if (w == dspid_pkg::W_POP_ACC)
			op_nxt = dspid_pkg::DSPID_OP_POP_TO_ACC;
		else if (w == dspid_pkg::W_PUSH_ACC)
			op_nxt = dspid_pkg::DSPID_OP_PUSH_FROM_ACC;
		else if (w == dspid_pkg::W_RETURN)
		begin
			op_nxt = dspid_pkg::DSPID_OP_RETURN;
			cyc_nxt = dspid_pkg::CYC_FOUR;
		end
		else if (w[15:4] == dspid_pkg::TOP_STATUS && w[3:0] != 4'h8 && w[3:0] != 4'h9)
			op_nxt = dspid_pkg::DSPID_OP_SET_STATUS_CONTROL;
		else if (w[15:4] == dspid_pkg::TOP_OR_IMM)
		begin
			op_nxt = dspid_pkg::DSPID_OP_OR_IMM;
			two_nxt = 1'b1;
			cyc_nxt = dspid_pkg::CYC_TWO;
		end
		else if (w[15:4] == dspid_pkg::TOP_XOR_IMM)
		begin
			op_nxt = dspid_pkg::DSPID_OP_XOR_IMM;
			two_nxt = 1'b1;
			cyc_nxt = dspid_pkg::CYC_TWO;
		end
		else if (hb == dspid_pkg::HB_MOD_AUX && w[7:3] == dspid_pkg::LB_LOAD_ARP)
			op_nxt = dspid_pkg::DSPID_OP_LOAD_ARP;
		else if (w[15:10] == dspid_pkg::TOP6_COND_RET)
		begin
			op_nxt = dspid_pkg::DSPID_OP_COND_RETURN;
			cyc_nxt = cond_true ? dspid_pkg::CYC_FOUR : dspid_pkg::CYC_TWO;
		end
		else if (w[15:13] == dspid_pkg::TOP3_MULT_IMM)
			op_nxt = dspid_pkg::DSPID_OP_MULTIPLY_IMM;
		else if (w[15:12] == dspid_pkg::TOP4_STORE_ACC)
			op_nxt = w[11] ? dspid_pkg::DSPID_OP_STORE_ACC_HIGH : dspid_pkg::DSPID_OP_STORE_ACC_LOW;
		else
		begin
			unique case (hb)
				dspid_pkg::HB_LD_MULT_STORE: op_nxt = dspid_pkg::DSPID_OP_LOAD_MULT_STORE_PRODUCT;
				dspid_pkg::HB_LD_MULT_SUB: op_nxt = dspid_pkg::DSPID_OP_LOAD_MULT_SUB_PRODUCT;
				dspid_pkg::HB_MULT_ACC, dspid_pkg::HB_MULT_ACC_MOVE:
				begin
					op_nxt = (hb == dspid_pkg::HB_MULT_ACC) ? dspid_pkg::DSPID_OP_MULTIPLY_ACCUMULATE
						: dspid_pkg::DSPID_OP_MULTIPLY_ACCUMULATE_MOVE;
					two_nxt = 1'b1;
					cyc_nxt = dspid_pkg::CYC_THREE;
				end
				dspid_pkg::HB_MOD_AUX: op_nxt = dspid_pkg::DSPID_OP_MODIFY_AUX_REGISTER;
				dspid_pkg::HB_MULT: op_nxt = dspid_pkg::DSPID_OP_MULTIPLY_OP;
				dspid_pkg::HB_MULT_ADD: op_nxt = dspid_pkg::DSPID_OP_MULTIPLY_ADD_PREV;
				dspid_pkg::HB_MULT_SUB: op_nxt = dspid_pkg::DSPID_OP_MULTIPLY_SUB_PREV;
				dspid_pkg::HB_NORM: op_nxt = dspid_pkg::DSPID_OP_NORMALIZE;
				dspid_pkg::HB_POP_MEM: op_nxt = dspid_pkg::DSPID_OP_POP_TO_MEMORY;
				dspid_pkg::HB_PUSH_MEM: op_nxt = dspid_pkg::DSPID_OP_PUSH_FROM_MEMORY;
				dspid_pkg::HB_REPEAT_IMM, dspid_pkg::HB_REPEAT_MEM:
					op_nxt = dspid_pkg::DSPID_OP_REPEAT_NEXT;
				dspid_pkg::HB_SQR_SUB: op_nxt = dspid_pkg::DSPID_OP_SQUARE_SUB_PREV;
				dspid_pkg::HB_SQR_ADD: op_nxt = dspid_pkg::DSPID_OP_SQUARE_ADD_PREV;
				dspid_pkg::HB_STORE_LONG:
				begin
					op_nxt = dspid_pkg::DSPID_OP_STORE_LONG_CONSTANT;
					two_nxt = 1'b1;
					cyc_nxt = dspid_pkg::CYC_TWO;
				end
				dspid_pkg::HB_SUB_BORROW: op_nxt = dspid_pkg::DSPID_OP_SUBTRACT_BORROW;
				dspid_pkg::HB_SUB_NOSX: op_nxt = dspid_pkg::DSPID_OP_SUBTRACT_NO_SIGNEXT;
				dspid_pkg::HB_ZERO_LOAD_RND: op_nxt = dspid_pkg::DSPID_OP_ZERO_LOAD_HIGH_ROUND;
				dspid_pkg::HB_PROD_SHIFT: op_nxt = dspid_pkg::DSPID_OP_SET_PRODUCT_SHIFT;
				default: legal_nxt = 1'b0;
			endcase
		end
	end

	// second word sequencing
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= dspid_pkg::DSPID_S_FIRST;
		else if (fetch_valid)
		begin
			unique case (state_r)
				dspid_pkg::DSPID_S_FIRST:
					if (two_nxt)
						state_r <= dspid_pkg::DSPID_S_SECOND;
				dspid_pkg::DSPID_S_SECOND:
					state_r <= dspid_pkg::DSPID_S_FIRST;
			endcase
		end
	end

	// one word per accepted fetch gives plus two across both words
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pc_r <= dspid_pkg::PC_RESET;
		else if (fetch_valid)
			pc_r <= pc_r + 16'h0001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			fetch_ready_r <= 1'b0;
		else
			fetch_ready_r <= 1'b1;
	end

	// issue stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			issue_valid_r <= 1'b0;
			op_r <= dspid_pkg::DSPID_OP_NONE;
			cycles_r <= dspid_pkg::CYC_ONE;
			two_word_r <= 1'b0;
			long_const_r <= '0;
			illegal_r <= 1'b0;
			indirect_r <= 1'b0;
			direct_offset_r <= 7'h00;
			indirect_ctrl_r <= 8'h00;
			aux_reg_index_r <= 3'h0;
			shift_count_field_r <= 4'h0;
			immediate_r <= 13'h0000;
			condition_type_field_r <= 2'h0;
			condition_mask_field_r <= 8'h00;
			status_action_r <= dspid_pkg::DSPID_ST_ENABLE_INT;
		end
		else if (fetch_valid && state_r == dspid_pkg::DSPID_S_SECOND)
		begin
			issue_valid_r <= 1'b1;
			long_const_r <= fetch_word;
		end
		else if (fetch_valid && two_nxt)
		begin
			issue_valid_r <= 1'b0;
			op_r <= op_nxt;
			cycles_r <= cyc_nxt;
			two_word_r <= 1'b1;
			illegal_r <= 1'b0;
			shift_count_field_r <= w[3:0];
			indirect_r <= w[7];
			direct_offset_r <= w[6:0];
			indirect_ctrl_r <= w[7:0];
		end
		else if (fetch_valid)
		begin
			issue_valid_r <= legal_nxt;
			op_r <= op_nxt;
			cycles_r <= cyc_nxt;
			two_word_r <= 1'b0;
			long_const_r <= '0;
			illegal_r <= ~legal_nxt;
			indirect_r <= w[7];
			direct_offset_r <= w[6:0];
			indirect_ctrl_r <= w[7:0];
			aux_reg_index_r <= w[2:0];
			shift_count_field_r <= (w[15:12] == dspid_pkg::TOP4_STORE_ACC) ? {1'b0, w[10:8]} : w[3:0];
			immediate_r <= w[12:0];
			condition_type_field_r <= w[9:8];
			condition_mask_field_r <= w[7:0];
			status_action_r <= dspid_pkg::dspid_status_t'(w[3:0]);
		end
		else
		begin
			issue_valid_r <= 1'b0;
			illegal_r <= 1'b0;
		end
	end

	property p_mult_acc_cycles;
		@(posedge clk) disable iff (!rst_n)
		(issue_valid_r && op_r == dspid_pkg::DSPID_OP_MULTIPLY_ACCUMULATE) |-> cycles_r == 3'h3 && two_word_r;
	endproperty
	a_mult_acc_cycles: assert property (p_mult_acc_cycles) else $error("multiply-accumulate cycle count wrong");

	property p_load_store_prod;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST && fetch_word[15:8] == 8'h71)
			|=> issue_valid_r && op_r == dspid_pkg::DSPID_OP_LOAD_MULT_STORE_PRODUCT;
	endproperty
	a_load_store_prod: assert property (p_load_store_prod) else $error("load store product misdecoded");

	property p_load_sub_prod;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST && fetch_word[15:8] == 8'h74)
			|=> op_r == dspid_pkg::DSPID_OP_LOAD_MULT_SUB_PRODUCT && cycles_r == 3'h1;
	endproperty
	a_load_sub_prod: assert property (p_load_sub_prod) else $error("load sub product misdecoded");

	property p_two_word_issue;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST && two_nxt) ##1 fetch_valid
			|=> issue_valid_r && long_const_r == $past(fetch_word) && pc_r == $past(pc_r, 2) + 16'h0002;
	endproperty
	a_two_word_issue: assert property (p_two_word_issue) else $error("second word handling wrong");

	property p_ret_cond;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST && fetch_word[15:10] == 6'h3b
			&& fetch_word != 16'hef00)
			|=> cycles_r == ($past(cond_true) ? 3'h4 : 3'h2);
	endproperty
	a_ret_cond: assert property (p_ret_cond) else $error("conditional return timing wrong");

	property p_store_half;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST && fetch_word[15:12] == 4'h9)
			|=> op_r == ($past(fetch_word[11]) ? dspid_pkg::DSPID_OP_STORE_ACC_HIGH
				: dspid_pkg::DSPID_OP_STORE_ACC_LOW);
	endproperty
	a_store_half: assert property (p_store_half) else $error("store half select wrong");

	property p_addr_split;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST)
			|=> indirect_r == $past(fetch_word[7]) && direct_offset_r == $past(fetch_word[6:0]);
	endproperty
	a_addr_split: assert property (p_addr_split) else $error("address field split wrong");

	property p_store_long;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST && fetch_word[15:8] == 8'hae)
			|=> !issue_valid_r ##1 (op_r == dspid_pkg::DSPID_OP_STORE_LONG_CONSTANT && cycles_r == 3'h2);
	endproperty
	a_store_long: assert property (p_store_long) else $error("store long constant wrong");

	property p_prod_to_acc;
		@(posedge clk) disable iff (!rst_n)
		(fetch_valid && state_r == dspid_pkg::DSPID_S_FIRST && fetch_word == 16'hbe03)
			|=> op_r == dspid_pkg::DSPID_OP_PRODUCT_TO_ACC && !two_word_r;
	endproperty
	a_prod_to_acc: assert property (p_prod_to_acc) else $error("product to accumulator wrong");

	c_two_word: cover property (@(posedge clk) disable iff (!rst_n) issue_valid_r && two_word_r);
	c_ret_taken: cover property (@(posedge clk) disable iff (!rst_n)
		issue_valid_r && op_r == dspid_pkg::DSPID_OP_COND_RETURN && cycles_r == 3'h4);
	c_illegal: cover property (@(posedge clk) disable iff (!rst_n) illegal_r);
endmodule

/* File: test/dspid_fetch_model.sv */
module dspid_fetch_model (
	input wire logic clk,
	input wire logic fetch_ready_r,
	output logic fetch_valid,
	output logic [15:0] fetch_word
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		fetch_valid = 1'b0;
		fetch_word = 16'h0000;
	end

	// words sent whole
	// called at a falling edge; holds the word through the taking edge
	task automatic push(input logic [15:0] w, output logic ok);
		for (int i = 0; i < 20 && fetch_ready_r !== 1'b1; i++)
			@(negedge clk);
		ok = (fetch_ready_r === 1'b1);
		fetch_valid = 1'b1;
		fetch_word = w;
		@(posedge clk);
		@(negedge clk);
	endtask

	// released bus shows the inverse so a stale word never matches
	task automatic idle();
		fetch_valid = 1'b0;
		fetch_word = ~fetch_word;
	endtask
endmodule

/* File: test/dsp_instruction_decode_l_to_z_tb_top.sv */
module dsp_instruction_decode_l_to_z_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_n;
	logic cond_true = 1'b0;
	logic fetch_valid;
	logic [15:0] fetch_word;
	logic fetch_ready_r;
	logic [15:0] pc_r;
	logic issue_valid_r;
	dspid_pkg::dspid_op_t op_r;
	logic [2:0] cycles_r;
	logic two_word_r;
	logic [15:0] long_const_r;
	logic indirect_r;
	logic [6:0] direct_offset_r;
	logic [7:0] indirect_ctrl_r;
	logic [2:0] aux_reg_index_r;
	logic [3:0] shift_count_field_r;
	logic [12:0] immediate_r;
	logic [1:0] condition_type_field_r;
	logic [7:0] condition_mask_field_r;
	dspid_pkg::dspid_status_t status_action_r;
	logic illegal_r;
	int fail_count = 0;
	int n_compared = 0;
	logic [15:0] exp_pc;

	always #12.5 clk = ~clk;

	dspid_fetch_model fm (
		.clk(clk),
		.fetch_ready_r(fetch_ready_r),
		.fetch_valid(fetch_valid),
		.fetch_word(fetch_word)
	);

	dspid_decode DUT (
		.clk(clk),
		.rst_n(rst_n),
		.fetch_valid(fetch_valid),
		.fetch_word(fetch_word),
		.cond_true(cond_true),
		.fetch_ready_r(fetch_ready_r),
		.pc_r(pc_r),
		.issue_valid_r(issue_valid_r),
		.op_r(op_r),
		.cycles_r(cycles_r),
		.two_word_r(two_word_r),
		.long_const_r(long_const_r),
		.indirect_r(indirect_r),
		.direct_offset_r(direct_offset_r),
		.indirect_ctrl_r(indirect_ctrl_r),
		.aux_reg_index_r(aux_reg_index_r),
		.shift_count_field_r(shift_count_field_r),
		.immediate_r(immediate_r),
		.condition_type_field_r(condition_type_field_r),
		.condition_mask_field_r(condition_mask_field_r),
		.status_action_r(status_action_r),
		.illegal_r(illegal_r)
	);

	task automatic print_verdict();
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic send(input logic [15:0] w);
		logic ok;
		fm.push(w, ok);
		exp_pc = exp_pc + 16'h0001;
		if (!ok)
		begin
			fail_count++;
			print_verdict();
		end
	endtask

	task automatic do_reset();
		fm.idle();
		rst_n = 1'b0;
		repeat (12) @(negedge clk);
		chk(pc_r, 16'h0000);
		chk(16'(issue_valid_r), 16'h0000);
		chk(16'(op_r), 16'(dspid_pkg::DSPID_OP_NONE));
		chk(16'(cycles_r), 16'h0001);
		chk(16'(fetch_ready_r), 16'h0000);
		rst_n = 1'b1;
		exp_pc = 16'h0000;
	endtask

	task automatic one(input logic [15:0] w, input dspid_pkg::dspid_op_t op);
		send(w);
		chk(16'(issue_valid_r), 16'h0001);
		chk(16'(op_r), 16'(op));
		chk(16'(cycles_r), 16'h0001);
		chk(16'(two_word_r), 16'h0000);
		chk(pc_r, exp_pc);
	endtask

	// back to back one-word opcodes
	task automatic t_one_word();
		one(16'h7105, dspid_pkg::DSPID_OP_LOAD_MULT_STORE_PRODUCT);
		one(16'h7480, dspid_pkg::DSPID_OP_LOAD_MULT_SUB_PRODUCT);
		one(16'h8b8b, dspid_pkg::DSPID_OP_LOAD_ARP);
		one(16'h8b00, dspid_pkg::DSPID_OP_MODIFY_AUX_REGISTER);
		one(16'h8b45, dspid_pkg::DSPID_OP_MODIFY_AUX_REGISTER);
		one(16'h5412, dspid_pkg::DSPID_OP_MULTIPLY_OP);
		one(16'hdfff, dspid_pkg::DSPID_OP_MULTIPLY_IMM);
		one(16'h5001, dspid_pkg::DSPID_OP_MULTIPLY_ADD_PREV);
		one(16'h5102, dspid_pkg::DSPID_OP_MULTIPLY_SUB_PREV);
		one(16'ha003, dspid_pkg::DSPID_OP_NORMALIZE);
		one(16'hbe03, dspid_pkg::DSPID_OP_PRODUCT_TO_ACC);
		one(16'h8a04, dspid_pkg::DSPID_OP_POP_TO_MEMORY);
		one(16'hbe32, dspid_pkg::DSPID_OP_POP_TO_ACC);
		one(16'hbe3c, dspid_pkg::DSPID_OP_PUSH_FROM_ACC);
		one(16'h7605, dspid_pkg::DSPID_OP_PUSH_FROM_MEMORY);
		one(16'hbb0a, dspid_pkg::DSPID_OP_REPEAT_NEXT);
		one(16'h0b0a, dspid_pkg::DSPID_OP_REPEAT_NEXT);
		one(16'h9f81, dspid_pkg::DSPID_OP_STORE_ACC_HIGH);
		one(16'h9081, dspid_pkg::DSPID_OP_STORE_ACC_LOW);
		one(16'h5306, dspid_pkg::DSPID_OP_SQUARE_SUB_PREV);
		one(16'h5207, dspid_pkg::DSPID_OP_SQUARE_ADD_PREV);
		one(16'h6408, dspid_pkg::DSPID_OP_SUBTRACT_BORROW);
		one(16'h6609, dspid_pkg::DSPID_OP_SUBTRACT_NO_SIGNEXT);
		one(16'h6810, dspid_pkg::DSPID_OP_ZERO_LOAD_HIGH_ROUND);
		one(16'hbf11, dspid_pkg::DSPID_OP_SET_PRODUCT_SHIFT);
	endtask

	// operand fields carried out of the first word
	task automatic t_fields();
		send(16'h8b8b);
		chk(16'(aux_reg_index_r), 16'h0003);
		send(16'h9d85);
		chk(16'(shift_count_field_r), 16'h0005);
		chk(16'(indirect_r), 16'h0001);
		chk(16'(indirect_ctrl_r), 16'h0085);
		send(16'h7125);
		chk(16'(indirect_r), 16'h0000);
		chk(16'(direct_offset_r), 16'h0025);
		send(16'hdabc);
		chk(16'(immediate_r), 16'h1abc);
	endtask

	// gap between the two words of one instruction
	task automatic two(input logic [15:0] w, input dspid_pkg::dspid_op_t op,
		input logic [2:0] cyc, input logic [15:0] c);
		send(w);
		chk(16'(issue_valid_r), 16'h0000);
		chk(16'(two_word_r), 16'h0001);
		chk(16'(op_r), 16'(op));
		chk(16'(cycles_r), 16'(cyc));
		fm.idle();
		@(negedge clk);
		send(c);
		chk(16'(issue_valid_r), 16'h0001);
		chk(long_const_r, c);
		chk(pc_r, exp_pc);
	endtask

	task automatic t_two_word();
		two(16'ha280, dspid_pkg::DSPID_OP_MULTIPLY_ACCUMULATE, 3'h3, 16'h1234);
		two(16'ha301, dspid_pkg::DSPID_OP_MULTIPLY_ACCUMULATE_MOVE, 3'h3, 16'hfedc);
		two(16'hbfc5, dspid_pkg::DSPID_OP_OR_IMM, 3'h2, 16'h00ff);
		chk(16'(shift_count_field_r), 16'h0005);
		two(16'hbe82, dspid_pkg::DSPID_OP_OR_IMM16, 3'h2, 16'h8001);
		two(16'hae80, dspid_pkg::DSPID_OP_STORE_LONG_CONSTANT, 3'h2, 16'h5a5a);
		two(16'hbfd3, dspid_pkg::DSPID_OP_XOR_IMM, 3'h2, 16'ha5a5);
		two(16'hbe83, dspid_pkg::DSPID_OP_XOR_IMM16, 3'h2, 16'h0f0f);
	endtask

	// second word right behind the first, then the issue pulse must drop
	task automatic t_two_back();
		send(16'hae7f);
		chk(16'(issue_valid_r), 16'h0000);
		send(16'h2468);
		chk(16'(issue_valid_r), 16'h0001);
		chk(long_const_r, 16'h2468);
		chk(16'(op_r), 16'(dspid_pkg::DSPID_OP_STORE_LONG_CONSTANT));
		chk(pc_r, exp_pc);
		send(16'h5001);
		chk(16'(issue_valid_r), 16'h0001);
		chk(long_const_r, 16'h0000);
		fm.idle();
		@(negedge clk);
		chk(16'({illegal_r, issue_valid_r}), 16'h0000);
	endtask

	task automatic t_return();
		cond_true = 1'b1;
		send(16'hee55);
		chk(16'(op_r), 16'(dspid_pkg::DSPID_OP_COND_RETURN));
		chk(16'(cycles_r), 16'h0004);
		chk(16'(condition_type_field_r), 16'h0002);
		chk(16'(condition_mask_field_r), 16'h0055);
		cond_true = 1'b0;
		send(16'hec3c);
		chk(16'(cycles_r), 16'h0002);
		send(16'hef00);
		chk(16'(op_r), 16'(dspid_pkg::DSPID_OP_RETURN));
		chk(16'(cycles_r), 16'h0004);
	endtask

	// every low nibble; 8 and 9 have no status action
	task automatic t_status();
		for (int n = 0; n < 16; n++)
		begin
			send({12'hbe4, 4'(n)});
			if (n == 8 || n == 9)
			begin
				chk(16'({illegal_r, issue_valid_r}), 16'h0002);
			end
			else
			begin
				chk(16'(op_r), 16'(dspid_pkg::DSPID_OP_SET_STATUS_CONTROL));
				chk(16'(status_action_r), 16'(n));
			end
		end
	endtask

	// reset in mid instruction drops the pending first word
	task automatic t_mid_reset();
		send(16'hae01);
		do_reset();
		one(16'h5412, dspid_pkg::DSPID_OP_MULTIPLY_OP);
	endtask

	initial
	begin
		do_reset();
		t_one_word();
		t_fields();
		t_two_word();
		t_two_back();
		t_return();
		t_status();
		t_mid_reset();
		fm.idle();
		repeat (3) @(negedge clk);
		print_verdict();
	end
endmodule
